// *** afm_fault_monitor.sv ***
// Operation
// - one 13-bit status word per axis
// - drive-only bits zero on axes 1, 2
// - per-axis fault mask resets to 268
// - mask write touches only its axis
// - drive alarm sets bit 3, flag 24
// - drive status code, 99h when normal
// - alarm clear cancels only clearable alarms
// - warning sets flag 25, loads code, no disable
// - link fault sets bit 2 of axis 0
// - link lost: monitors invalid, param cmds error
// - keep retrying link after loss
// - clear/reset blocks until link back
// - run error stops or traps, records line/id
// - fixed run-time error codes
// - motion error when status AND mask nonzero
// - motion error drops servo, flags, records axis
// - homing zero or drive reset clears error
`timescale 1ns/1ps
`default_nettype none
module afm_fault_monitor
  import afm_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // drive side
  input  wire logic        DRV_ALARM,
  input  wire logic        DRV_ALARM_CLEARABLE,
  input  wire logic        DRV_WARN,
  input  wire logic [7:0]  DRV_CODE,
  input  wire logic        DRV_LINK_OK,
  output var  logic        DRV_LINK_RETRY,
  output var  logic        DRV_ALARM_CLEAR,
  output var  logic        DRV_SYS_RESET,
  output var  logic        SERVO_ON,
  // axis events
  input  wire logic [12:0] AXIS0_EVT,
  input  wire logic [12:0] AXIS1_EVT,
  input  wire logic [12:0] AXIS2_EVT,
  // program error report
  input  wire logic        RUN_ERR_VALID,
  input  wire logic [7:0]  RUN_ERR_CODE,
  input  wire logic [15:0] RUN_ERR_LINE,
  output var  logic        PROG_TRAP,
  output var  logic        PROG_STOP,
  // monitor validity
  output var  logic        MONITOR_VALID
);

  // status words
  logic [12:0] stat_r [AFM_NUM_AXES];
  logic [12:0] evt    [AFM_NUM_AXES];
  logic [12:0] impl   [AFM_NUM_AXES];
  logic [12:0] mask   [AFM_NUM_AXES];
  logic [AFM_NUM_AXES-1:0] hit;

  // control and results
  logic        servo_sw_r;
  logic        trap_en_r;
  logic        merr_r;
  logic [1:0]  err_axis_r;
  logic [7:0]  drv_code_r;
  logic        flag_alarm_r;
  logic        flag_warn_r;
  logic [7:0]  run_err_r;
  logic [15:0] err_line_r;
  logic        param_err_r;
  afm_cmd_st_t cst_r;
  logic        pend_clr_r;
  logic        pend_rst_r;
  logic        clr_armed_r;

  // bus state
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  assign evt[0]  = AXIS0_EVT;
  assign evt[1]  = AXIS1_EVT;
  assign evt[2]  = AXIS2_EVT;
  assign impl[0] = AXIS0_IMPL;
  assign impl[1] = AXIS1_IMPL;
  assign impl[2] = AXIS2_IMPL;

  // write channel join
  wire       aw_ok   = aw_hold_r | S_AXI_AWVALID;
  wire       w_ok    = w_hold_r | S_AXI_WVALID;
  wire       wr_go   = aw_ok & w_ok & ~S_AXI_BVALID;
  wire [7:0] wa      = aw_hold_r ? awaddr_r : S_AXI_AWADDR;
  wire [31:0] wd     = w_hold_r ? wdata_r : S_AXI_WDATA;
  wire [3:0] ws      = w_hold_r ? wstrb_r : S_AXI_WSTRB;
  wire       lo_full = ws[0] & ws[1];

  // write decode
  wire wr_mask0 = wr_go & lo_full & (wa == REG_MASK0);
  wire wr_mask1 = wr_go & lo_full & (wa == REG_MASK1);
  wire wr_mask2 = wr_go & lo_full & (wa == REG_MASK2);
  wire wr_ctrl  = wr_go & ws[0] & (wa == REG_CTRL);
  wire wr_cmd   = wr_go & ws[0] & (wa == REG_CMD);
  wire wr_known = (wa == REG_MASK0) | (wa == REG_MASK1) | (wa == REG_MASK2) |
                  (wa == REG_CTRL) | (wa == REG_CMD);

  wire cmd_home  = wr_cmd & wd[CMD_HOME0];
  wire cmd_clr   = wr_cmd & wd[CMD_DRIVE_ALARM_CLEAR_CMD];
  wire cmd_rst   = wr_cmd & wd[CMD_DRIVE_SYSTEM_RESET_CMD];
  wire cmd_param = wr_cmd & (wd[CMD_PARAM_RD] | wd[CMD_PARAM_WR]);

  // clear/reset only complete with link up
  wire do_clr = DRV_LINK_OK & (cmd_clr | pend_clr_r);
  wire do_rst = DRV_LINK_OK & (cmd_rst | pend_rst_r);

  // mask registers
  afm_mask_if mif [AFM_NUM_AXES] ();
  assign mif[0].wr    = wr_mask0;
  assign mif[1].wr    = wr_mask1;
  assign mif[2].wr    = wr_mask2;
  assign mif[0].wdata = wd[12:0];
  assign mif[1].wdata = wd[12:0];
  assign mif[2].wdata = wd[12:0];

  generate
    for (genvar g = 0; g < AFM_NUM_AXES; g++) begin : g_ax
      afm_mask_reg u_mask (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .m     (mif[g])
      );
      assign mask[g] = mif[g].mask;
      assign hit[g]  = |(stat_r[g] & mask[g]);
    end
  endgenerate

  // status next values
  logic [12:0] stat_nxt [AFM_NUM_AXES];
  always_comb begin
    for (int i = 0; i < AFM_NUM_AXES; i++) begin
      stat_nxt[i] = (stat_r[i] | evt[i]) & impl[i];
      if (cmd_home | do_rst) stat_nxt[i] = evt[i] & impl[i];
    end
    if (DRV_ALARM) stat_nxt[0][ST_DRV_ALARM] = 1'b1;
    else if (clr_armed_r) stat_nxt[0][ST_DRV_ALARM] = 1'b0;
    if (!DRV_LINK_OK) stat_nxt[0][ST_DRV_COMM] = 1'b1;
    else if (do_clr) stat_nxt[0][ST_DRV_COMM] = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < AFM_NUM_AXES; i++) stat_r[i] <= 13'h0000;
    end else begin
      for (int i = 0; i < AFM_NUM_AXES; i++) stat_r[i] <= stat_nxt[i];
    end
  end

  // first failing axis, lowest wins
  wire [1:0] first_ax = hit[0] ? 2'd0 : (hit[1] ? 2'd1 : 2'd2);
  wire       merr_clr = cmd_home | do_rst;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      merr_r     <= 1'b0;
      err_axis_r <= 2'd0;
    end else if (|hit & ~merr_r) begin
      merr_r     <= 1'b1;
      err_axis_r <= first_ax;
    end else if (merr_clr) begin
      merr_r     <= 1'b0;
    end
  end

  // servo switch, forced off by motion error
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      servo_sw_r <= 1'b0;
      trap_en_r  <= 1'b0;
    end else if (wr_ctrl) begin
      servo_sw_r <= wd[0];
      trap_en_r  <= wd[1];
    end else if (merr_r) begin
      servo_sw_r <= 1'b0;
    end
  end

  // drive status code and flags
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      drv_code_r   <= DRIVE_STATUS_CODE_OK;
      flag_alarm_r <= 1'b0;
      flag_warn_r  <= 1'b0;
      clr_armed_r  <= 1'b0;
    end else begin
      clr_armed_r  <= (do_clr & DRV_ALARM_CLEARABLE) | (clr_armed_r & DRV_ALARM);
      drv_code_r   <= (DRV_ALARM | DRV_WARN) ? DRV_CODE : DRIVE_STATUS_CODE_OK;
      flag_alarm_r <= DRV_ALARM;
      flag_warn_r  <= DRV_WARN;
    end
  end

  // clear/reset command sequencer
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cst_r      <= CMD_IDLE;
      pend_clr_r <= 1'b0;
      pend_rst_r <= 1'b0;
    end else begin
      case (cst_r)
        CMD_IDLE: begin
          if ((cmd_clr | cmd_rst) & ~DRV_LINK_OK) begin
            cst_r      <= CMD_WAIT_LINK;
            pend_clr_r <= cmd_clr;
            pend_rst_r <= cmd_rst;
          end
        end
        CMD_WAIT_LINK: begin
          if (DRV_LINK_OK) begin
            cst_r      <= CMD_IDLE;
            pend_clr_r <= 1'b0;
            pend_rst_r <= 1'b0;
          end
        end
        default: cst_r <= CMD_IDLE;
      endcase
    end
  end

  // drive-facing pulses and link retry
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      DRV_ALARM_CLEAR <= 1'b0;
      DRV_SYS_RESET   <= 1'b0;
      DRV_LINK_RETRY  <= 1'b0;
      SERVO_ON        <= 1'b0;
      MONITOR_VALID   <= 1'b0;
      param_err_r     <= 1'b0;
    end else begin
      DRV_ALARM_CLEAR <= do_clr;
      DRV_SYS_RESET   <= do_rst;
      DRV_LINK_RETRY  <= ~DRV_LINK_OK;
      SERVO_ON        <= servo_sw_r & ~merr_r & ~|hit & ~DRV_ALARM;
      MONITOR_VALID   <= DRV_LINK_OK;
      if (cmd_param) param_err_r <= ~DRV_LINK_OK;
    end
  end

  // run-time error capture
  wire link_cmd_err = cmd_param & ~DRV_LINK_OK;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      run_err_r  <= 8'h00;
      err_line_r <= 16'h0000;
      PROG_TRAP  <= 1'b0;
      PROG_STOP  <= 1'b0;
    end else begin
      PROG_TRAP <= 1'b0;
      PROG_STOP <= 1'b0;
      if (RUN_ERR_VALID) begin
        run_err_r  <= RUN_ERR_CODE;
        err_line_r <= RUN_ERR_LINE;
        PROG_TRAP  <= trap_en_r;
        PROG_STOP  <= ~trap_en_r;
      end else if (link_cmd_err) begin
        run_err_r <= ERR_REPOWER;
        PROG_TRAP <= trap_en_r;
        PROG_STOP <= ~trap_en_r;
      end
    end
  end

  // read mux
  wire [7:0]  ra = S_AXI_ARADDR;
  logic [31:0] rmux;
  logic        rhit;
  always_comb begin
    rhit = 1'b1;
    if (ra == REG_STATUS0) rmux = {19'h0, stat_r[0]};
    else if (ra == REG_STATUS1) rmux = {19'h0, stat_r[1]};
    else if (ra == REG_STATUS2) rmux = {19'h0, stat_r[2]};
    else if (ra == REG_MASK0) rmux = {19'h0, mask[0]};
    else if (ra == REG_MASK1) rmux = {19'h0, mask[1]};
    else if (ra == REG_MASK2) rmux = {19'h0, mask[2]};
    else if (ra == REG_CTRL) rmux = {30'h0, trap_en_r, servo_sw_r};
    else if (ra == REG_MERR) rmux = {29'h0, err_axis_r, merr_r};
    else if (ra == REG_DRV_STAT) rmux = {24'h0, drv_code_r};
    else if (ra == REG_CMD) rmux = {27'h0, param_err_r, 2'b00, cst_r == CMD_WAIT_LINK, 1'b0};
    else if (ra == REG_RUNERR) rmux = {err_line_r, 8'h00, run_err_r};
    else if (ra == REG_FLAGS) rmux = {6'h0, flag_warn_r, flag_alarm_r, 24'h0};
    else begin
      rmux = 32'h0000_0000;
      rhit = 1'b0;
    end
  end

  // axi write channel
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else if (wr_go) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b1;
      S_AXI_BRESP   <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_hold_r     <= 1'b1;
        awaddr_r      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_hold_r     <= 1'b1;
        wdata_r      <= S_AXI_WDATA;
        wstrb_r      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // axi read channel
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rmux;
      S_AXI_RRESP   <= rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID & S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : afm_fault_monitor
`default_nettype wire

// *** afm_pkg.sv ***
`default_nettype none
package afm_pkg;

  localparam int          AFM_NUM_AXES     = 3;
  localparam int          AFM_STAT_W       = 13;

  // status bit positions
  localparam int          ST_FE_WARN       = 1;
  localparam int          ST_DRV_COMM      = 2;
  localparam int          ST_DRV_ALARM     = 3;
  localparam int          ST_FWD_LIM       = 4;
  localparam int          ST_REV_LIM       = 5;
  localparam int          ST_HOMING        = 6;
  localparam int          ST_FEED_HOLD     = 7;
  localparam int          ST_FE_LIMIT      = 8;
  localparam int          ST_FWD_SW        = 9;
  localparam int          ST_REV_SW        = 10;
  localparam int          ST_CANCEL        = 11;
  localparam int          ST_ENC_OVSPD     = 12;

  // implemented bits per axis
  localparam logic [12:0] AXIS0_IMPL       = 13'h0FFE;
  localparam logic [12:0] AXIS1_IMPL       = 13'h1EF0;
  localparam logic [12:0] AXIS2_IMPL       = 13'h0EF0;
  localparam logic [12:0] MASK_RESET       = 13'h010C;

  localparam logic [7:0]  DRIVE_STATUS_CODE_OK    = 8'h99;

  // input flag numbers
  localparam int          FLAG_DRV_ALARM   = 24;
  localparam int          FLAG_DRV_WARN    = 25;

  // run-time error codes
  localparam logic [7:0]  ERR_DIV_ZERO     = 8'h09;
  localparam logic [7:0]  ERR_RESET_SERVO  = 8'h54;
  localparam logic [7:0]  ERR_REPOWER      = 8'h56;
  localparam logic [7:0]  ERR_NET_TIMEOUT  = 8'h59;

  // register byte offsets
  localparam logic [7:0]  REG_STATUS0      = 8'h00;
  localparam logic [7:0]  REG_STATUS1      = 8'h04;
  localparam logic [7:0]  REG_STATUS2      = 8'h08;
  localparam logic [7:0]  REG_MASK0        = 8'h0C;
  localparam logic [7:0]  REG_MASK1        = 8'h10;
  localparam logic [7:0]  REG_MASK2        = 8'h14;
  localparam logic [7:0]  REG_CTRL         = 8'h18;
  localparam logic [7:0]  REG_MERR         = 8'h1C;
  localparam logic [7:0]  REG_DRV_STAT     = 8'h20;
  localparam logic [7:0]  REG_CMD          = 8'h24;
  localparam logic [7:0]  REG_RUNERR       = 8'h28;
  localparam logic [7:0]  REG_FLAGS        = 8'h2C;

  // command register bits
  localparam int          CMD_HOME0        = 0;
  localparam int          CMD_DRIVE_ALARM_CLEAR_CMD    = 1;
  localparam int          CMD_DRIVE_SYSTEM_RESET_CMD    = 2;
  localparam int          CMD_PARAM_RD     = 3;
  localparam int          CMD_PARAM_WR     = 4;

  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT_LINK} afm_cmd_st_t;

endpackage : afm_pkg
`default_nettype wire

// *** afm_mask_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface afm_mask_if;
  logic        wr;
  logic [12:0] wdata;
  logic [12:0] mask;
  modport ctl (output wr, output wdata, input mask);
  modport reg_side (input wr, input wdata, output mask);
endinterface : afm_mask_if
`default_nettype wire

// *** afm_mask_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
module afm_mask_reg
  import afm_pkg::*;
(
  // clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // mask access
  afm_mask_if.reg_side m
);
  logic [12:0] mask_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mask_r <= MASK_RESET;
    else if (m.wr) mask_r <= m.wdata;
  end

  assign m.mask = mask_r;
endmodule : afm_mask_reg
`default_nettype wire

// *** afm_fault_monitor_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module afm_fault_monitor_asserts
  import afm_pkg::*;
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // drive and program side
  input wire logic        DRV_ALARM,
  input wire logic        DRV_LINK_OK,
  input wire logic        DRV_LINK_RETRY,
  input wire logic        DRV_ALARM_CLEAR,
  input wire logic        DRV_SYS_RESET,
  input wire logic        SERVO_ON,
  input wire logic        PROG_TRAP,
  input wire logic        PROG_STOP,
  input wire logic        MONITOR_VALID
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY && !S_AXI_BVALID |=> S_AXI_BVALID) else $error("no write response");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("no read response");
  a_alarm_servo_off: assert property (
    DRV_ALARM [*2] |-> !SERVO_ON) else $error("servo on during alarm");
  a_monitor_link: assert property (
    RESETN |=> MONITOR_VALID == $past(DRV_LINK_OK)) else $error("monitor valid wrong");
  a_link_retry: assert property (
    !DRV_LINK_OK [*2] |-> DRV_LINK_RETRY) else $error("no link retry");
  a_clear_link_up: assert property (
    DRV_ALARM_CLEAR || DRV_SYS_RESET |-> $past(DRV_LINK_OK)) else $error("command on dead link");
  a_clear_pulse: assert property (DRV_ALARM_CLEAR |=> !DRV_ALARM_CLEAR)
    else $error("clear not a pulse");
  a_trap_or_stop: assert property (
    !(PROG_TRAP && PROG_STOP)) else $error("trap and stop together");
endmodule : afm_fault_monitor_asserts
`default_nettype wire

// *** afm_drv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module afm_drv_model
  import afm_pkg::*;
(
  // clock
  input wire logic        clk,
  // scenario control
  input wire logic        alarm_req,
  input wire logic        clr_ok_req,
  input wire logic        warn_req,
  input wire logic        pwr_cycle,
  input wire logic        link_req,
  input wire logic [7:0]  code_req,
  // commands from board
  input wire logic        alarm_clear,
  input wire logic        sys_reset,
  // drive outputs
  output logic            alarm,
  output logic            clearable,
  output logic            warn,
  output logic            link_ok,
  output logic [7:0]      code
);
  initial alarm = 1'b0;
  // only a power cycle ends a hard alarm
  always @(posedge clk) begin
    if (pwr_cycle) alarm <= 1'b0;
    else if (alarm_req) alarm <= 1'b1;
    else if ((alarm_clear || sys_reset) && clr_ok_req) alarm <= 1'b0;
  end
  assign clearable = alarm & clr_ok_req;
  assign warn      = warn_req;
  assign link_ok   = link_req;
  assign code      = (alarm || warn_req) ? code_req : ~code_req;
endmodule : afm_drv_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import afm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rcode = 8'h00, cd_rq = 8'h00, d_code;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rev = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb = 4'hF;
  logic [12:0] ev0 = 13'h0, ev1 = 13'h0, ev2 = 13'h0;
  logic [15:0] rline = 16'h0, lf = 16'h697A;
  logic al_rq = 1'b0, clr_rq = 1'b0, wn_rq = 1'b0, pwr = 1'b0, lk_rq = 1'b1;
  logic d_al, d_clr, d_wn, d_lk, d_aclr, d_rst, d_retry, servo, trap, stop, monv;
  logic [7:0] codes [4] = '{ERR_DIV_ZERO, ERR_RESET_SERVO, ERR_REPOWER, ERR_NET_TIMEOUT};
  int err_count = 0, total_checks = 0, cyc = 0;
  int mask [3], stat [3];

  always #20 clk = ~clk;

  afm_fault_monitor afm_fault_monitor_inst (.CLK_SYS(clk), .RESETN(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DRV_ALARM(d_al), .DRV_ALARM_CLEARABLE(d_clr), .DRV_WARN(d_wn), .DRV_CODE(d_code),
    .DRV_LINK_OK(d_lk), .DRV_LINK_RETRY(d_retry), .DRV_ALARM_CLEAR(d_aclr),
    .DRV_SYS_RESET(d_rst), .SERVO_ON(servo), .AXIS0_EVT(ev0), .AXIS1_EVT(ev1),
    .AXIS2_EVT(ev2), .RUN_ERR_VALID(rev), .RUN_ERR_CODE(rcode), .RUN_ERR_LINE(rline),
    .PROG_TRAP(trap), .PROG_STOP(stop), .MONITOR_VALID(monv));

  afm_drv_model afm_drv_model_inst (.clk(clk), .alarm_req(al_rq), .clr_ok_req(clr_rq),
    .warn_req(wn_rq), .pwr_cycle(pwr), .link_req(lk_rq), .code_req(cd_rq),
    .alarm_clear(d_aclr), .sys_reset(d_rst), .alarm(d_al), .clearable(d_clr),
    .warn(d_wn), .link_ok(d_lk), .code(d_code));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] exp_merr();
    logic [31:0] r;
    r = 32'h0;
    for (int i = 2; i >= 0; i--) if ((stat[i] & mask[i]) != 0) r = {29'h0, 2'(i), 1'b1};
    return r;
  endfunction : exp_merr

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1; w = 1'b1; b = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b) begin
      @(posedge clk);
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
      if (bvalid) begin b = 1'b1; rs = bresp; end
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
    logic ar, r;
    logic [31:0] d;
    ar = 1'b1; r = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r) begin
      @(posedge clk);
      if (ar && arready) begin ar = 1'b0; arvalid <= 1'b0; end
      if (rvalid) begin r = 1'b1; d = rdata; rs = rresp; end
    end
    rready <= 1'b0;
    chk(d & m, e & m);
  endtask : rdc

  task automatic chk_all();
    for (int i = 0; i < 3; i++) begin
      rdc(REG_MASK0 + 8'(4 * i), mask[i]);
      rdc(REG_STATUS0 + 8'(4 * i), stat[i]);
    end
  endtask : chk_all

  task automatic evp(input logic [12:0] e0, input logic [12:0] e1, input logic [12:0] e2);
    @(posedge clk);
    ev0 <= e0; ev1 <= e1; ev2 <= e2;
    @(posedge clk);
    ev0 <= 13'h0; ev1 <= 13'h0; ev2 <= 13'h0;
    tk(3);
  endtask : evp

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin mask[i] = 16'h10C; stat[i] = 0; end
    chk_all();
    rdc(REG_DRV_STAT, DRIVE_STATUS_CODE_OK);
    rdc(8'h30, 32'h0);
    chk(rs, RESP_SLVERR);
    wr(8'h30, 32'h1);
    chk(rs, RESP_SLVERR);
    lf = lfsr(lf);
    mask[1] = lf[12:0];
    wr(REG_MASK1, mask[1]);
    chk(rs, RESP_OKAY);
    wstrb <= 4'h1;
    wr(REG_MASK2, 32'h0);
    wstrb <= 4'hF;
    chk_all();
    for (int i = 0; i < 3; i++) begin mask[i] = 0; wr(REG_MASK0 + 8'(4 * i), 32'h0); end
    evp(13'h1FFF, 13'h1FFF, 13'h1FFF);
    stat[0] = AXIS0_IMPL; stat[1] = AXIS1_IMPL; stat[2] = AXIS2_IMPL;
    chk_all();
    rdc(REG_MERR, 32'h0, 32'h1);
    wr(REG_CMD, 32'h1);
    for (int i = 0; i < 3; i++) stat[i] = 0;
    chk_all();
    wr(REG_CTRL, 32'h1);
    tk(3);
    chk(servo, 1'b1);
    mask[1] = 16'h10; mask[2] = 16'h10;
    wr(REG_MASK1, 32'h10);
    wr(REG_MASK2, 32'h10);
    evp(13'h0, 13'h10, 13'h10);
    stat[1] = 16; stat[2] = 16;
    rdc(REG_MERR, exp_merr());
    chk(servo, 1'b0);
    wr(REG_CMD, 32'h1);
    stat[1] = 0; stat[2] = 0;
    rdc(REG_MERR, 32'h0, 32'h1);
    chk_all();
    wr(REG_CTRL, 32'h1);
    lf = lfsr(lf);
    @(posedge clk);
    wn_rq <= 1'b1; cd_rq <= lf[7:0];
    tk(4);
    rdc(REG_FLAGS, 32'h02000000, 32'h03000000);
    rdc(REG_DRV_STAT, {24'h0, cd_rq});
    chk(servo, 1'b1);
    @(posedge clk);
    wn_rq <= 1'b0;
    mask[0] = 16'h10C;
    wr(REG_MASK0, 32'h10C);
    wr(REG_CTRL, 32'h0);
    @(posedge clk);
    al_rq <= 1'b1;
    @(posedge clk);
    al_rq <= 1'b0;
    tk(4);
    stat[0] = 8;
    rdc(REG_STATUS0, stat[0]);
    rdc(REG_FLAGS, 32'h01000000, 32'h03000000);
    rdc(REG_DRV_STAT, {24'h0, cd_rq});
    rdc(REG_MERR, exp_merr());
    wr(REG_CMD, 32'h2);
    tk(4);
    rdc(REG_STATUS0, 32'h8, 32'h8);
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    wr(REG_CMD, 32'h4);
    tk(3);
    rdc(REG_MERR, 32'h0, 32'h1);
    rdc(REG_STATUS0, 32'h0);
    @(posedge clk);
    clr_rq <= 1'b1; al_rq <= 1'b1;
    @(posedge clk);
    al_rq <= 1'b0;
    tk(4);
    rdc(REG_STATUS0, 32'h8);
    wr(REG_CMD, 32'h2);
    tk(4);
    rdc(REG_STATUS0, 32'h0);
    rdc(REG_DRV_STAT, DRIVE_STATUS_CODE_OK);
    wr(REG_CMD, 32'h1);
    @(posedge clk);
    lk_rq <= 1'b0;
    tk(4);
    stat[0] = 4;
    rdc(REG_STATUS0, 32'h4, 32'h4);
    rdc(REG_MERR, exp_merr());
    chk(monv, 1'b0);
    wr(REG_CMD, 32'h8);
    tk(3);
    rdc(REG_RUNERR, {24'h0, ERR_REPOWER}, 32'hFF);
    wr(REG_CMD, 32'h2);
    rdc(REG_CMD, 32'h2, 32'h2);
    @(posedge clk);
    lk_rq <= 1'b1;
    tk(6);
    rdc(REG_CMD, 32'h0, 32'h2);
    rdc(REG_STATUS0, 32'h0, 32'h4);
    chk(monv, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, {30'h0, i[0], 1'b0});
      lf = lfsr(lf);
      @(posedge clk);
      rev <= 1'b1; rcode <= codes[i]; rline <= lf;
      @(posedge clk);
      rev <= 1'b0;
      @(negedge clk);
      chk({trap, stop}, {i[0], ~i[0]});
      tk(3);
      rdc(REG_RUNERR, {lf, 8'h00, codes[i]}, 32'hFFFF00FF);
    end
    conclude();
  end
endmodule : tb

bind afm_fault_monitor afm_fault_monitor_asserts afm_fault_monitor_asserts_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .DRV_ALARM(DRV_ALARM), .DRV_LINK_OK(DRV_LINK_OK), .DRV_LINK_RETRY(DRV_LINK_RETRY),
  .DRV_ALARM_CLEAR(DRV_ALARM_CLEAR), .DRV_SYS_RESET(DRV_SYS_RESET), .SERVO_ON(SERVO_ON),
  .PROG_TRAP(PROG_TRAP), .PROG_STOP(PROG_STOP), .MONITOR_VALID(MONITOR_VALID));
`default_nettype wire
